//--- hdl/frame_codec_defs.vh
`ifndef FRAME_CODEC_DEFS_VH
`define FRAME_CODEC_DEFS_VH

// ****************************************
// register byte offsets (own map)
// ****************************************
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_RX_HDR     8'h08
`define OFS_RX_BLOCK   8'h0c
`define OFS_RX_DATA    8'h10
`define OFS_TX_BLOCK   8'h14
`define OFS_TX_DATA    8'h18
`define OFS_TX_GO      8'h1c
`define OFS_RX_BYTE    8'h20
`define OFS_TX_BYTE    8'h24

// ****************************************
// header and block field positions
// ****************************************
`define HDR_SHORT_BIT  7
`define HDR_MULTI_BIT  6
`define HDR_ACK_BIT    5
`define HDR_CONT_BIT   6
`define HDR_FRZ_BIT    5
`define HDR_IND_BIT    4
`define HDR_SCH_BIT    3
`define HDR_SLG_BIT    2
`define BLK_LAST_BIT   7
`define BROADCAST_ADDR 8'h00

// ****************************************
// crc and reset values
// ****************************************
`define CRC_POLY_REFL  16'ha001
`define CRC_INIT       16'h0000
`define CTRL_RESET     8'h01
`define RX_DEPTH_LOG2  8  // longest request frame fits without wrap
`define TX_DEPTH_LOG2  8

`endif

//--- hdl/codec_buffer.v
`timescale 1ns/1ps
// ****************************************
// small byte memory with registered read
// ****************************************
module codec_buffer #(
  parameter AW = 8,
  parameter DW = 8
) (
  // clock
  input  wire          hclk,
  // write side
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // read side
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];  // storage, no reset needed

  // write port and registered read port
  always @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // codec_buffer

//--- hdl/telemetry_frame_codec.v
// Notes on behaviour
// - frame is header, blocks, two crc bytes
// - short-response set exactly when no blocks
// - one address byte, zero is broadcast
// - block byte one: last mark, function
// - block byte two: zero bit, length
// - accept frame only on zero residue
// - crc fed lsb first per byte
// - reply header flag layout, then address
// - continuation flag when reply too long
// - freeze flag until frozen counts read
// - indication flag until master acknowledges
// - event flags never asserted here
// - last mark only on final block
// - echo function unless request failed
// - continuation only for functions 0,1,2,3,7
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "frame_codec_defs.vh"
module telemetry_frame_codec #(
  parameter RXAW = `RX_DEPTH_LOG2,
  parameter TXAW = `TX_DEPTH_LOG2
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // received byte stream
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  input  wire        rx_end,
  // transmitted byte stream
  output reg         tx_valid,
  output reg  [7:0]  tx_byte,
  output reg         tx_last,
  input  wire        tx_ready,
  // device state flags
  input  wire        frozen,
  input  wire        frozen_read,
  input  wire        ind_pending,
  // frame events
  output reg         frame_ok,
  output reg         frame_drop
);
  // ****************************************
  // crc step, one byte, lsb first
  // ****************************************
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg [15:0]   t;
    begin
      t = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0] ^ d[i])  // lsb of byte enters first
          t = (t >> 1) ^ `CRC_POLY_REFL;  // reflected polynomial
        else
          t = t >> 1;
      end
      crc_byte = t;
    end
  endfunction

  // continuation allowed only for these functions
  function cont_ok;
    input [6:0] f;
    begin
      cont_ok = (f == 7'h00) || (f == 7'h01) || (f == 7'h02) ||
                (f == 7'h03) || (f == 7'h07);
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]      ctrl;         // [7:0] own address
  reg             cont_req;     // software wants continuation
  reg             fn_fail;      // request could not be performed
  reg  [6:0]      fail_code;    // function code used on failure
  reg             ind_flag;     // sticky indication change
  reg             frz_flag;     // sticky freeze
  reg  [7:0]      rx_hdr0;      // captured master flags
  reg  [7:0]      rx_addr;      // captured address
  reg  [6:0]      rx_func;      // captured function
  reg  [6:0]      rx_len;       // captured length
  reg             rx_has_blk;   // frame carried a block
  reg             rx_ready;     // frame waiting for software
  reg  [15:0]     rx_crc;       // running receive crc
  reg  [RXAW-1:0] rx_cnt;       // byte index in frame
  reg  [RXAW-1:0] rx_rd_ptr;    // software read index
  reg  [TXAW-1:0] tx_wr_ptr;    // software fill index
  reg  [TXAW-1:0] tx_rd_ptr;    // sender index
  reg  [TXAW-1:0] tx_len;       // body length to send
  reg  [15:0]     tx_crc;       // running transmit crc
  reg  [2:0]      tx_state;     // one-hot sender
  reg  [1:0]      tx_hdr_idx;   // header byte index
  reg             tx_crc_idx;   // crc byte index
  reg             tx_fetch;     // memory read in flight
  // ahb data-phase capture
  reg             dp_wr;
  reg             dp_rd;
  reg  [7:0]      dp_addr;

  localparam TX_IDLE = 3'b001;
  localparam TX_BODY = 3'b010;
  localparam TX_CRC  = 3'b100;

  wire [7:0]      rx_mem_q;
  wire [7:0]      tx_mem_q;
  wire            ap_ok = hsel & hready & htrans[1];
  wire            wr_go = dp_wr;
  wire [7:0]      own_addr = ctrl;

  // ****************************************
  // byte buffers
  // ****************************************
  codec_buffer #(.AW(RXAW), .DW(8)) u_rx_mem (
    .hclk    (hclk),
    .wr_en   (rx_valid & ~rx_ready),
    .wr_addr (rx_cnt),
    .wr_data (rx_byte),
    .rd_addr (rx_rd_ptr),
    .rd_data (rx_mem_q)
  );

  codec_buffer #(.AW(TXAW), .DW(8)) u_tx_mem (
    .hclk    (hclk),
    .wr_en   (wr_go && dp_addr == `OFS_TX_BYTE),
    .wr_addr (tx_wr_ptr),
    .wr_data (hwdata[7:0]),
    .rd_addr (tx_rd_ptr),
    .rd_data (tx_mem_q)
  );

  // ****************************************
  // receive parser
  // ****************************************
  // header byte 0, address, function, length, data, crc
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt     <= {RXAW{1'b0}};
      rx_crc     <= `CRC_INIT;
      rx_hdr0    <= 8'h00;
      rx_addr    <= 8'h00;
      rx_func    <= 7'h00;
      rx_len     <= 7'h00;
      rx_has_blk <= 1'b0;
      rx_ready   <= 1'b0;
      frame_ok   <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      frame_ok   <= 1'b0;
      frame_drop <= 1'b0;
      // software releases the frame; a new verdict below wins
      if (wr_go && dp_addr == `OFS_STATUS && hwdata[0]) begin
        rx_ready <= 1'b0;
      end
      // frames arriving while one is pending are ignored whole
      if (rx_valid && !rx_ready) begin
        rx_crc <= crc_byte(rx_crc, rx_byte);  // whole frame incl crc
        rx_cnt <= rx_cnt + 1'b1;
        case (rx_cnt)
          0: rx_hdr0 <= rx_byte;  // master flags
          1: rx_addr <= rx_byte;  // one address byte
          2: rx_func <= rx_byte[6:0];  // one block, mark set by master
          3: rx_len  <= rx_byte[6:0];  // 7-bit length
          default: rx_func <= rx_func;
        endcase
      end
      if (rx_end && !rx_ready) begin
        rx_cnt <= {RXAW{1'b0}};
        rx_crc <= `CRC_INIT;
        // zero residue and our or broadcast address
        if (rx_crc == 16'h0000 &&
            (rx_addr == own_addr || rx_addr == `BROADCAST_ADDR)) begin
          rx_ready   <= 1'b1;
          frame_ok   <= 1'b1;
          rx_has_blk <= ~rx_hdr0[`HDR_SHORT_BIT];  // short means no block
        end else begin
          frame_drop <= 1'b1;  // silent discard
        end
      end
    end
  end

  // ****************************************
  // remote status flags
  // ****************************************
  // sets win over clears so no event is lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frz_flag <= 1'b0;
      ind_flag <= 1'b0;
    end else begin
      if (frozen)
        frz_flag <= 1'b1;  // accumulators frozen
      else if (frozen_read)
        frz_flag <= 1'b0;  // counts read by master
      if (ind_pending)
        ind_flag <= 1'b1;  // changes pending
      else if (frame_ok && rx_hdr0[`HDR_ACK_BIT])
        ind_flag <= 1'b0;  // master acknowledged
    end
  end

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr     <= 1'b0;
      dp_rd     <= 1'b0;
      dp_addr   <= 8'h00;
      hreadyout <= 1'b1;  // never inserts wait states
      hresp     <= 1'b0;  // always okay
    end else begin
      dp_wr     <= ap_ok & hwrite;
      dp_rd     <= ap_ok & ~hwrite;
      dp_addr   <= ap_ok ? haddr[7:0] : dp_addr;
    end
  end

  // read data mux; unmapped reads zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_ok && !hwrite) begin
      case (haddr[7:0])
        `OFS_CTRL:     hrdata <= {24'h000000, ctrl};
        `OFS_STATUS:   hrdata <= {26'h0, frz_flag, ind_flag, tx_state[0],
                                  rx_has_blk, 1'b0, rx_ready};
        `OFS_RX_HDR:   hrdata <= {16'h0000, rx_addr, rx_hdr0};
        `OFS_RX_BLOCK: hrdata <= {17'h0, rx_len, 1'b0, rx_func};
        `OFS_RX_DATA:  hrdata <= {24'h000000, rx_mem_q};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // control writes
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= `CTRL_RESET;
      cont_req  <= 1'b0;
      fn_fail   <= 1'b0;
      fail_code <= 7'h00;
      rx_rd_ptr <= {RXAW{1'b0}};
      tx_wr_ptr <= {TXAW{1'b0}};
      tx_len    <= {TXAW{1'b0}};
    end else begin
      // reading rx data advances pointer; memory latency is one cycle
      if (ap_ok && !hwrite && haddr[7:0] == `OFS_RX_DATA)
        rx_rd_ptr <= rx_rd_ptr + 1'b1;
      if (wr_go) begin
        case (dp_addr)
          `OFS_CTRL:     ctrl <= hwdata[7:0];
          `OFS_RX_BYTE:  rx_rd_ptr <= hwdata[RXAW-1:0];
          `OFS_TX_BLOCK: begin
            cont_req  <= hwdata[8];
            fn_fail   <= hwdata[9];
            fail_code <= hwdata[6:0];
          end
          `OFS_TX_BYTE:  tx_wr_ptr <= tx_wr_ptr + 1'b1;
          `OFS_TX_GO:    tx_len <= tx_wr_ptr;
          default:       ctrl <= ctrl;
        endcase
      end
      if (tx_state[2] && tx_crc_idx && tx_ready)
        tx_wr_ptr <= {TXAW{1'b0}};  // ready for next reply
    end
  end

  // ****************************************
  // transmit sequencer
  // ****************************************
  // software fills blocks (fn/len/data) with last mark; header is built here
  wire       tx_go_hit = wr_go && dp_addr == `OFS_TX_GO;
  wire [7:0] reply_hdr0 = {(tx_wr_ptr == {TXAW{1'b0}}),          // no block
                           cont_req & cont_ok(rx_func),
                           frz_flag, ind_flag,
                           1'b0, 1'b0, 2'b00};                   // no event data

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state   <= TX_IDLE;
      tx_valid   <= 1'b0;
      tx_byte    <= 8'h00;
      tx_last    <= 1'b0;
      tx_crc     <= `CRC_INIT;
      tx_hdr_idx <= 2'd0;
      tx_crc_idx <= 1'b0;
      tx_rd_ptr  <= {TXAW{1'b0}};
      tx_fetch   <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          // valid, last and fetch are already low whenever idle is entered
          if (tx_go_hit) begin
            tx_byte    <= reply_hdr0;
            tx_valid   <= 1'b1;
            tx_crc     <= `CRC_INIT;
            tx_hdr_idx <= 2'd0;
            tx_rd_ptr  <= {TXAW{1'b0}};
            tx_state   <= TX_BODY;
          end
        end
        TX_BODY: begin
          if (tx_valid && tx_ready) begin
            tx_crc   <= crc_byte(tx_crc, tx_byte);
            tx_valid <= 1'b0;
            if (tx_hdr_idx == 2'd0) begin
              tx_byte    <= own_addr;  // responding address
              tx_valid   <= 1'b1;
              tx_hdr_idx <= 2'd1;
            end else begin
              tx_hdr_idx <= 2'd2;
              tx_fetch   <= (tx_rd_ptr != tx_len);
              if (tx_rd_ptr == tx_len)
                tx_state <= TX_CRC;
            end
          end else if (tx_fetch) begin
            // block bytes carry echoed or failure code and last mark
            tx_byte   <= (tx_rd_ptr == {TXAW{1'b0}} && fn_fail) ?
                         {tx_mem_q[`BLK_LAST_BIT], fail_code} : tx_mem_q;
            tx_valid  <= 1'b1;
            tx_fetch  <= 1'b0;
            tx_rd_ptr <= tx_rd_ptr + 1'b1;
          end
          tx_crc_idx <= 1'b0;
        end
        TX_CRC: begin
          // low byte then high byte
          if (!tx_valid) begin
            tx_byte  <= tx_crc[7:0];
            tx_valid <= 1'b1;
          end else if (tx_ready) begin
            if (!tx_crc_idx) begin
              tx_byte    <= tx_crc[15:8];
              tx_last    <= 1'b1;
              tx_crc_idx <= 1'b1;
            end else begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              tx_state <= TX_IDLE;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
endmodule // telemetry_frame_codec

//--- verif/codec_asserts.sv
`timescale 1ns/1ps
// ****************************************
// reply stream and frame verdict checks
// ****************************************
module codec_asserts (
  // clock and reset
  input wire       hclk,
  input wire       hresetn,
  // bus answer
  input wire       hreadyout,
  input wire       hresp,
  // byte streams
  input wire       rx_end,
  input wire       tx_valid,
  input wire [7:0] tx_byte,
  input wire       tx_last,
  input wire       tx_ready,
  // frame verdicts
  input wire       frame_ok,
  input wire       frame_drop
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg  [15:0] crc;                          // residue of reply bytes so far
  reg  [3:0]  cnt;                          // reply bytes taken, saturating
  reg         mid;                          // inside a reply
  reg         shr;                          // short flag of current reply
  wire        hs = tx_valid && tx_ready;    // byte handed over
  // one byte into the reflected check, lsb first
  function [15:0] step(input [15:0] c, input [7:0] d);
    integer i;
    begin
      step = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1)
        step = step[0] ? (step >> 1) ^ 16'ha001 : step >> 1;
    end
  endfunction
  // follow each reply, cleared at its last byte
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= 16'h0000;
      cnt <= 4'h0;
      mid <= 1'b0;
      shr <= 1'b0;
    end else if (hs) begin
      crc <= tx_last ? 16'h0000 : step(crc, tx_byte);
      cnt <= tx_last ? 4'h0 : ((cnt == 4'hf) ? cnt : cnt + 4'h1);
      mid <= !tx_last;
      if (!mid) shr <= tx_byte[7];
    end
  end
  a_bus_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_verdict_cause: assert property ((frame_ok || frame_drop) |-> $past(rx_end))
    else $error("verdict without frame end one cycle before");
  a_verdict_single: assert property (!(frame_ok && frame_drop))
    else $error("frame both accepted and dropped");
  a_ok_pulse: assert property (frame_ok |=> !frame_ok)
    else $error("accept pulse longer than one cycle");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)
    && $stable(tx_last)) else $error("reply byte changed while stalled");
  a_hdr_low_zero: assert property (hs && !mid |-> tx_byte[3:0] == 4'h0)
    else $error("reply header low bits not zero");
  a_short_flag: assert property (hs && tx_last |-> shr == (cnt == 4'h3))
    else $error("short flag disagrees with body");
  a_frame_min: assert property (hs && tx_last |-> cnt >= 4'h3)
    else $error("reply shorter than header and check");
  a_crc_zero: assert property (hs && tx_last |-> step(crc, tx_byte) == 16'h0000)
    else $error("reply check residue not zero");
endmodule // codec_asserts

//--- verif/master_station.sv
`timescale 1ns/1ps
// ****************************************
// polling station on the far side
// ****************************************
module master_station (
  // clock
  input  wire        hclk,
  // request bytes toward the device
  output logic       rx_valid,
  output logic [7:0] rx_byte,
  output logic       rx_end,
  // reply bytes from the device
  input  wire        tx_valid,
  input  wire  [7:0] tx_byte,
  input  wire        tx_last,
  output logic       tx_ready
);
  logic [7:0] got[$];  // reply bytes in arrival order
  logic       slow;    // stall three cycles in four
  logic [1:0] ph;      // stall phase
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b0;
    slow = 1'b0;
    ph = 2'h0;
  end
  // reflected check, zero start, lsb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // take reply bytes, stalling when asked
  always @(posedge hclk) begin
    if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_byte);
    ph <= ph + 2'h1;
    tx_ready <= !slow || ph == 2'h0;
  end
  // one request: header, at most one block, check low byte first
  task send(input logic [7:0] h, a, input logic bk, input logic [6:0] fn,
            input logic [7:0] dq[$], input logic bad);
    logic [7:0]  q[$];
    logic [15:0] c;
    q = {h | (bk ? 8'h00 : 8'h80), a};
    if (bk) begin
      q.push_back({1'b1, fn});
      q.push_back({1'b0, 7'(dq.size())});
      q = {q, dq};
    end
    c = 16'h0000;
    foreach (q[i]) c = crc16(c, q[i]);
    c[15] = c[15] ^ bad;
    q = {q, c[7:0], c[15:8]};
    foreach (q[i]) begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_byte <= q[i];
    end
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_byte <= ~q[q.size()-1];
    @(posedge hclk);
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
  endtask
endmodule // master_station

//--- verif/telemetry_frame_codec_bench.sv
`timescale 1ns/1ps
module telemetry_frame_codec_bench;
  // ****************************************
  // signals
  // ****************************************
  logic        hclk, hresetn, hsel, hwrite, frozen, frozen_read, ind_pending;
  logic [31:0] haddr, hwdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
  wire         frame_ok, frame_drop;
  wire  [7:0]  rx_byte, tx_byte;
  int          failures, checks, k, nb;
  logic [7:0]  own, b[$], d[$];
  logic [6:0]  fl[8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h07, 7'h04, 7'h05, 7'h7f};
  telemetry_frame_codec dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_valid, .rx_byte, .rx_end,
    .tx_valid, .tx_byte, .tx_last, .tx_ready, .frozen, .frozen_read, .ind_pending,
    .frame_ok, .frame_drop);
  master_station mst (.hclk, .rx_valid, .rx_byte, .rx_end, .tx_valid, .tx_byte, .tx_last,
    .tx_ready);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // a wait that ran out ends the run
  task lim(input int n, m);
    if (n >= m) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      final_report;
    end
  endtask
  task rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    lim(n, 20);
  endtask
  // one single word transfer, read data lands in r
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask
  // send a request and check verdict and stored fields
  task frame(input logic [7:0] a, h, input logic bk, input logic [6:0] fn, input logic bad, ok);
    int n;
    d = {};
    repeat ($urandom_range(3)) d.push_back(8'($urandom));
    mst.send(h, a, bk, fn, d, bad);
    n = 0;
    do begin @(posedge hclk); n++; end while (frame_ok !== 1'b1 && frame_drop !== 1'b1 && n < 20);
    lim(n, 20);
    chk({frame_ok, frame_drop}, {ok, !ok}, "verdict");
    if (ok) begin
      bus(1'b0, 8'h08, 0);
      chk(r[15:0], {a, h | (bk ? 8'h00 : 8'h80)}, "rx header");
      bus(1'b0, 8'h04, 0);
      chk({r[2], r[0]}, {bk, 1'b1}, "rx status");
      if (bk) bus(1'b0, 8'h0c, 0);
      if (bk) chk({r[14:8], r[6:0]}, {7'(d.size()), fn}, "rx block");
      if (bk) bus(1'b1, 8'h20, 32'h4);
      foreach (d[i]) begin
        if (bk) bus(1'b0, 8'h10, 0);
        if (bk) chk(r[7:0], d[i], "rx data");
      end
      bus(1'b1, 8'h04, 1);
    end
  endtask
  // build a reply and check every byte the station got
  task reply(input logic cr, fail, input int n0, input logic [7:0] hx);
    logic [15:0] c;
    int n;
    b = {};
    bus(1'b1, 8'h14, {22'h0, fail, cr, 1'b0, 7'h2a});
    repeat (n0) begin
      b.push_back(8'($urandom));
      bus(1'b1, 8'h24, {24'h0, b[$]});
    end
    if (fail && n0 > 0) b[0][6:0] = 7'h2a;
    mst.got = {};
    bus(1'b1, 8'h1c, 0);
    n = 0;
    do begin @(posedge hclk); n++; end while (mst.got.size() < n0 + 4 && n < 300);
    lim(n, 300);
    chk(mst.got.size(), n0 + 4, "reply length");
    chk(mst.got[0], hx, "reply header");
    chk(mst.got[1], own, "reply address");
    c = 16'h0000;
    foreach (mst.got[i]) begin
      c = mst.crc16(c, mst.got[i]);
      if (i > 1 && i < n0 + 2) chk(mst.got[i], b[i-2], "reply body");
    end
    chk(c, 0, "reply residue");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {hsel, hwrite, frozen, frozen_read, ind_pending} = 5'h00;
    haddr = 0;
    hwdata = 0;
    htrans = 2'b00;
    hsize = 3'b010;
    hresetn = 1'b0;
    failures = 0;
    checks = 0;
    void'($urandom(97));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 0);
    chk(r, 32'h1, "ctrl reset");
    bus(1'b0, 8'h04, 0);
    chk(r[5:0] & 6'h3d, 6'h08, "status reset");
    bus(1'b1, 8'h30, 32'hffffffff);
    bus(1'b0, 8'h30, 0);
    chk(r, 0, "unmapped");
    own = 8'($urandom_range(254, 1));
    bus(1'b1, 8'h00, {24'h0, own});
    bus(1'b0, 8'h00, 0);
    chk(r[7:0], own, "own address");
    $display("test registers done");
    // freeze first, counts read before the sixth reply
    @(posedge hclk) frozen <= 1'b1;
    @(posedge hclk) frozen <= 1'b0;
    for (k = 0; k < 8; k++) begin
      if (k == 5) @(posedge hclk) frozen_read <= 1'b1;
      if (k == 5) @(posedge hclk) frozen_read <= 1'b0;
      mst.slow = k[0];
      nb = (k == 2) ? 0 : 1 + k % 3;
      frame(own, 8'h00, 1'b1, fl[k], 1'b0, 1'b1);
      reply(1'b1, k == 6, nb, {nb == 0, k < 5, k < 5, 5'h00});
    end
    $display("test replies done");
    frame(own, 8'h00, 1'b1, 7'h01, 1'b1, 1'b0);
    frame(own + 8'h01, 8'h00, 1'b1, 7'h01, 1'b0, 1'b0);
    $display("test discards done");
    @(posedge hclk) ind_pending <= 1'b1;
    @(posedge hclk) ind_pending <= 1'b0;
    bus(1'b0, 8'h04, 0);
    chk(r[4], 1'b1, "indication set");
    frame(8'h00, 8'h20, 1'b0, 7'h00, 1'b0, 1'b1);
    bus(1'b0, 8'h04, 0);
    chk(r[4], 1'b0, "indication cleared");
    $display("test indication done");
    final_report;
  end
endmodule // telemetry_frame_codec_bench
bind telemetry_frame_codec codec_asserts checker_i (.hclk, .hresetn, .hreadyout, .hresp,
  .rx_end, .tx_valid, .tx_byte, .tx_last, .tx_ready, .frame_ok, .frame_drop);
